// [logic/adfc_pkg.sv]
// Package of register map, field positions and reset values for the digital feature control bank.
package adfc_pkg;
    localparam int ADFC_AW = 13;
    localparam logic [12:0] ADFC_OFS_RANGE_PIN = 13'h002a;
    localparam logic [12:0] ADFC_OFS_OUT_ASSIGN = 13'h002e;
    localparam logic [12:0] ADFC_OFS_SYNC = 13'h0100;
    localparam logic [12:0] ADFC_OFS_MISC = 13'h0101;
    localparam logic [12:0] ADFC_OFS_QEC_EN = 13'h0110;
    localparam logic [12:0] ADFC_OFS_QEC_FORCE = 13'h0111;
    localparam logic [12:0] ADFC_OFS_GAIN_BW = 13'h0112;
    localparam logic [12:0] ADFC_OFS_PHASE_BW = 13'h0113;
    localparam logic [12:0] ADFC_OFS_DC_BW = 13'h0114;
    localparam logic [12:0] ADFC_OFS_GAIN_LO = 13'h0116;
    localparam logic [12:0] ADFC_OFS_GAIN_HI = 13'h0117;
    localparam logic [12:0] ADFC_OFS_PHASE_LO = 13'h0118;
    localparam logic [12:0] ADFC_OFS_PHASE_HI = 13'h0119;
    localparam logic [12:0] ADFC_OFS_DCI_LO = 13'h011a;
    localparam logic [12:0] ADFC_OFS_DCI_HI = 13'h011b;
    localparam logic [12:0] ADFC_OFS_DCQ_LO = 13'h011c;
    localparam logic [12:0] ADFC_OFS_DCQ_HI = 13'h011d;
    // Reset values.
    localparam logic [7:0] ADFC_RST_RANGE_PIN = 8'h01;
    localparam logic [7:0] ADFC_RST_OUT_ASSIGN = 8'h00;
    localparam logic [7:0] ADFC_RST_SYNC = 8'h01;
    localparam logic [7:0] ADFC_RST_MISC = 8'h88;
    localparam logic [7:0] ADFC_RST_QEC = 8'h00;
    localparam logic [4:0] ADFC_RST_BW = 5'h02;
    // Writable bit masks; open bits read as zero.
    localparam logic [7:0] ADFC_MSK_BIT0 = 8'h01;
    localparam logic [7:0] ADFC_MSK_SYNC = 8'h07;
    localparam logic [7:0] ADFC_MSK_MISC = 8'h8d;
    localparam logic [7:0] ADFC_MSK_QEC_EN = 8'h3f;
    localparam logic [7:0] ADFC_MSK_FORCE = 8'h07;
    // Field positions.
    localparam int ADFC_SYNC_MASTER = 0;
    localparam int ADFC_SYNC_DIV_EN = 1;
    localparam int ADFC_SYNC_ONESHOT = 2;
    localparam int ADFC_MISC_PD_DIS = 0;
    localparam int ADFC_MISC_RUN_OSC = 2;
    localparam int ADFC_MISC_DET_EN = 3;
    localparam int ADFC_MISC_OE_PIN_EN = 7;
    // Serial frame: 16 instruction bits then 8 data bits.
    localparam int ADFC_INSTR_BITS = 16;
    localparam int ADFC_FRAME_BITS = 24;
    localparam int ADFC_CNT_W = 5;
    // Encode-rate monitor window: clk cycles per check at 100 MHz, 1 us window.
    localparam int ADFC_CLK_MHZ = 100;
    localparam int ADFC_WIN_NS = 1000;
    localparam int ADFC_WIN_CYC = ADFC_WIN_NS * ADFC_CLK_MHZ / 1000;
    // Five edges per microsecond is five mega-samples per second.
    localparam logic [7:0] ADFC_LOW_RATE_EDGES = 8'h05;
endpackage

// [logic/adfc_rate_det.sv]
// Encode-rate detector that flags encode clocks slower than about five mega-samples per second.
`timescale 1ns/10ps
`default_nettype none
module adfc_rate_det
    import adfc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic enable,
    input wire logic encode_tick,
    output logic low_rate
);
    typedef struct packed {
        logic [9:0] win;
        logic [7:0] edges;
        logic low;
    } adfc_det_t;
    adfc_det_t st_r;
    adfc_det_t st_nxt;

    // Count encode ticks over a fixed window; disabled detection reports no low rate.
    always_comb begin
        st_nxt = st_r;
        if (!enable) begin
            st_nxt = '0;
        end else if (st_r.win == 10'(ADFC_WIN_CYC - 1)) begin
            st_nxt.win = '0;
            st_nxt.low = (st_r.edges < ADFC_LOW_RATE_EDGES);
            st_nxt.edges = '0;
        end else begin
            st_nxt.win = st_r.win + 10'h001;
            if (encode_tick && st_r.edges != 8'hff) begin
                st_nxt.edges = st_r.edges + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign low_rate = st_r.low;
endmodule
`default_nettype wire

// [logic/adfc_serial_slave.sv]
// Serial port slave: 16-bit instruction (read flag, 2 length bits, 13 address bits) then one data byte.
`timescale 1ns/10ps
`default_nettype none
module adfc_serial_slave
    import adfc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic csn,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    output logic [12:0] addr,
    output logic [7:0] wdata,
    output logic wr_stb,
    input wire logic [7:0] rdata
);
    typedef struct packed {
        logic sclk_d;
        logic [4:0] cnt;
        logic [15:0] instr;
        logic [7:0] data;
        logic [7:0] shout;
        logic drive;
        logic stb;
    } adfc_ser_t;
    adfc_ser_t st_r;
    adfc_ser_t st_nxt;

    // Shift on the sampled rising edge of sclk; read data is loaded after the instruction.
    always_comb begin
        st_nxt = st_r;
        st_nxt.sclk_d = sclk;
        st_nxt.stb = 1'b0;
        if (csn) begin
            st_nxt.cnt = '0;
            st_nxt.drive = 1'b0;
        end else if (sclk && !st_r.sclk_d) begin
            if (st_r.cnt < 5'(ADFC_INSTR_BITS)) begin
                st_nxt.instr = {st_r.instr[14:0], sdi};
                if (st_r.cnt == 5'(ADFC_INSTR_BITS - 1)) begin
                    st_nxt.drive = st_r.instr[14];
                end
            end else begin
                st_nxt.data = {st_r.data[6:0], sdi};
                st_nxt.shout = {st_r.shout[6:0], 1'b0};
            end
            if (st_r.cnt == 5'(ADFC_FRAME_BITS - 1)) begin
                st_nxt.stb = !st_r.instr[15];
                st_nxt.drive = 1'b0;
                st_nxt.cnt = '0;
            end else begin
                st_nxt.cnt = st_r.cnt + 5'h01;
            end
        end
        // Capture read data once the address is complete.
        if (!csn && st_r.cnt == 5'(ADFC_INSTR_BITS) && st_r.drive && !(sclk && !st_r.sclk_d)
            && st_r.shout == 8'h00) begin
            st_nxt.shout = rdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign addr = st_r.instr[12:0];
    assign wdata = st_r.data;
    assign wr_stb = st_r.stb;
    assign sdo = st_r.shout[7];
    assign sdo_oe = st_r.drive;
endmodule
`default_nettype wire

// [logic/adfc_top.sv]
// Digital feature control register bank: sync gating, oscillator, pin enables and correction controls.
//
// Functional notes
// - No sync function acts unless the master sync enable bit is high.
// - Divider sync enable gates sync pulses; continuous resync while one-shot is low.
// - With one-shot high, divider aligns to first pulse and ignores later ones.
// - Hardware clears divider sync enable after a one-shot synchronisation.
// - Output-enable pin acts as active-low enable only while its enable bit is set.
// - Low-rate detect enable starts oscillator when encode rate falls below ~5 MSPS.
// - Run-oscillator bit forces the low-rate oscillator on regardless of detector.
// - Pull-down disable bit removes the weak pull-down on the serial data pin.
// - Each freeze bit halts its estimation and holds the last correction value.
// - Separate enables switch dc, phase and gain corrections independently.
// - Force-dc applies stored initial dc I and dc Q values.
// - Force-phase applies the stored initial phase value.
// - Force-gain applies the stored initial gain value.
// - Five-bit gain loop exponent sets gain loop time constant, reset two.
// - Five-bit phase loop exponent sets phase loop time constant, reset two.
// - Five-bit dc loop exponent sets dc loop time constant, reset two.
// - Initial words: gain 15, phase 13, dc I and Q 14 bits, split low/high.
`timescale 1ns/10ps
`default_nettype none
module adfc_top
    import adfc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic csn,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    output logic sdio_pulldown_en,
    input wire logic sync_pulse,
    output logic divider_sync,
    input wire logic encode_tick,
    output logic low_rate_internal_oscillator_run,
    input wire logic output_enable_low_pin,
    output logic outputs_enabled,
    output logic range_pin_enable,
    output logic output_channel_select,
    output logic [2:0] correction_enable,
    output logic [2:0] estimation_frozen,
    output logic [2:0] force_initial,
    output logic [4:0] gain_loop_exponent,
    output logic [4:0] phase_loop_exponent,
    output logic [4:0] dc_loop_exponent,
    output logic [14:0] initial_gain,
    output logic [12:0] initial_phase,
    output logic [13:0] initial_dc_i,
    output logic [13:0] initial_dc_q
);
    ////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        logic [7:0] range_pin;
        logic [7:0] out_assign;
        logic [7:0] sync_ctl;
        logic [7:0] misc;
        logic [7:0] qec_en;
        logic [7:0] qec_force;
        logic [4:0] gain_bw;
        logic [4:0] phase_bw;
        logic [4:0] dc_bw;
        logic [14:0] gain_init;
        logic [12:0] phase_init;
        logic [13:0] dci_init;
        logic [13:0] dcq_init;
        logic sync_out;
        logic sync_done;
    } adfc_st_t;
    adfc_st_t st_r;
    adfc_st_t st_nxt;

    logic [12:0] bus_addr;
    logic [7:0] bus_wdata;
    logic bus_wr;
    logic [7:0] bus_rdata;
    logic low_rate;
    logic sync_gate;

    // Masks a write so open bits never store anything.
    function automatic logic [7:0] adfc_masked(input logic [7:0] d, input logic [7:0] m);
        return d & m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Serial port and rate detector.

    adfc_serial_slave u_ser (
        .clk(clk),
        .resetn(resetn),
        .sclk(sclk),
        .csn(csn),
        .sdi(sdio_in),
        .sdo(sdio_out),
        .sdo_oe(sdio_oe),
        .addr(bus_addr),
        .wdata(bus_wdata),
        .wr_stb(bus_wr),
        .rdata(bus_rdata)
    );

    adfc_rate_det u_det (
        .clk(clk),
        .resetn(resetn),
        .enable(st_r.misc[ADFC_MISC_DET_EN]),
        .encode_tick(encode_tick),
        .low_rate(low_rate)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; open bits were never stored so they read as zero.

    always_comb begin
        bus_rdata = 8'h00;
        unique case (bus_addr)
            ADFC_OFS_RANGE_PIN: bus_rdata = st_r.range_pin;
            ADFC_OFS_OUT_ASSIGN: bus_rdata = st_r.out_assign;
            ADFC_OFS_SYNC: bus_rdata = st_r.sync_ctl;
            ADFC_OFS_MISC: bus_rdata = st_r.misc;
            ADFC_OFS_QEC_EN: bus_rdata = st_r.qec_en;
            ADFC_OFS_QEC_FORCE: bus_rdata = st_r.qec_force;
            ADFC_OFS_GAIN_BW: bus_rdata = {3'h0, st_r.gain_bw};
            ADFC_OFS_PHASE_BW: bus_rdata = {3'h0, st_r.phase_bw};
            ADFC_OFS_DC_BW: bus_rdata = {3'h0, st_r.dc_bw};
            ADFC_OFS_GAIN_LO: bus_rdata = st_r.gain_init[7:0];
            ADFC_OFS_GAIN_HI: bus_rdata = {1'h0, st_r.gain_init[14:8]};
            ADFC_OFS_PHASE_LO: bus_rdata = st_r.phase_init[7:0];
            ADFC_OFS_PHASE_HI: bus_rdata = {3'h0, st_r.phase_init[12:8]};
            ADFC_OFS_DCI_LO: bus_rdata = st_r.dci_init[7:0];
            ADFC_OFS_DCI_HI: bus_rdata = {2'h0, st_r.dci_init[13:8]};
            ADFC_OFS_DCQ_LO: bus_rdata = st_r.dcq_init[7:0];
            ADFC_OFS_DCQ_HI: bus_rdata = {2'h0, st_r.dcq_init[13:8]};
            default: bus_rdata = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sync gating: a pulse reaches the divider only with both enables set.

    assign sync_gate = st_r.sync_ctl[ADFC_SYNC_MASTER]
        && st_r.sync_ctl[ADFC_SYNC_DIV_EN]
        && !(st_r.sync_ctl[ADFC_SYNC_ONESHOT] && st_r.sync_done);

    ////////////////////////////////////////////////////////////////////////////
    // Next state: register writes, then hardware updates which win over software.

    always_comb begin
        st_nxt = st_r;
        st_nxt.sync_out = 1'b0;
        if (bus_wr) begin
            unique case (bus_addr)
                ADFC_OFS_RANGE_PIN: st_nxt.range_pin = adfc_masked(bus_wdata, ADFC_MSK_BIT0);
                ADFC_OFS_OUT_ASSIGN: st_nxt.out_assign = adfc_masked(bus_wdata, ADFC_MSK_BIT0);
                ADFC_OFS_SYNC: begin
                    st_nxt.sync_ctl = adfc_masked(bus_wdata, ADFC_MSK_SYNC);
                    // A fresh arm starts a new one-shot.
                    st_nxt.sync_done = 1'b0;
                end
                ADFC_OFS_MISC: st_nxt.misc = adfc_masked(bus_wdata, ADFC_MSK_MISC);
                ADFC_OFS_QEC_EN: st_nxt.qec_en = adfc_masked(bus_wdata, ADFC_MSK_QEC_EN);
                ADFC_OFS_QEC_FORCE: st_nxt.qec_force = adfc_masked(bus_wdata, ADFC_MSK_FORCE);
                ADFC_OFS_GAIN_BW: st_nxt.gain_bw = bus_wdata[4:0];
                ADFC_OFS_PHASE_BW: st_nxt.phase_bw = bus_wdata[4:0];
                ADFC_OFS_DC_BW: st_nxt.dc_bw = bus_wdata[4:0];
                ADFC_OFS_GAIN_LO: st_nxt.gain_init[7:0] = bus_wdata;
                ADFC_OFS_GAIN_HI: st_nxt.gain_init[14:8] = bus_wdata[6:0];
                ADFC_OFS_PHASE_LO: st_nxt.phase_init[7:0] = bus_wdata;
                ADFC_OFS_PHASE_HI: st_nxt.phase_init[12:8] = bus_wdata[4:0];
                ADFC_OFS_DCI_LO: st_nxt.dci_init[7:0] = bus_wdata;
                ADFC_OFS_DCI_HI: st_nxt.dci_init[13:8] = bus_wdata[5:0];
                ADFC_OFS_DCQ_LO: st_nxt.dcq_init[7:0] = bus_wdata;
                ADFC_OFS_DCQ_HI: st_nxt.dcq_init[13:8] = bus_wdata[5:0];
                default: ;
            endcase
        end
        // A gated pulse resyncs the divider. Only a one-shot arm drops the enable, so
        // continuous mode keeps resyncing; the clear beats a same-cycle write.
        if (sync_pulse && sync_gate) begin
            st_nxt.sync_out = 1'b1;
            if (st_r.sync_ctl[ADFC_SYNC_ONESHOT]) begin
                st_nxt.sync_ctl[ADFC_SYNC_DIV_EN] = 1'b0;
            end
            st_nxt.sync_done = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_r <= '0;
            st_r.range_pin <= ADFC_RST_RANGE_PIN;
            st_r.out_assign <= ADFC_RST_OUT_ASSIGN;
            st_r.sync_ctl <= ADFC_RST_SYNC;
            st_r.misc <= ADFC_RST_MISC;
            st_r.qec_en <= ADFC_RST_QEC;
            st_r.qec_force <= ADFC_RST_QEC;
            st_r.gain_bw <= ADFC_RST_BW;
            st_r.phase_bw <= ADFC_RST_BW;
            st_r.dc_bw <= ADFC_RST_BW;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs to the converter datapath.

    assign divider_sync = st_r.sync_out;
    // Pin is ignored while its enable is low; then outputs stay enabled.
    assign outputs_enabled = !st_r.misc[ADFC_MISC_OE_PIN_EN] || !output_enable_low_pin;
    // The forced run overrides whatever the detector decides.
    assign low_rate_internal_oscillator_run = st_r.misc[ADFC_MISC_RUN_OSC] || low_rate;
    assign sdio_pulldown_en = !st_r.misc[ADFC_MISC_PD_DIS];
    assign range_pin_enable = st_r.range_pin[0];
    assign output_channel_select = st_r.out_assign[0];
    assign correction_enable = st_r.qec_en[2:0];
    assign estimation_frozen = st_r.qec_en[5:3];
    assign force_initial = st_r.qec_force[2:0];
    assign gain_loop_exponent = st_r.gain_bw;
    assign phase_loop_exponent = st_r.phase_bw;
    assign dc_loop_exponent = st_r.dc_bw;
    assign initial_gain = st_r.gain_init;
    assign initial_phase = st_r.phase_init;
    assign initial_dc_i = st_r.dci_init;
    assign initial_dc_q = st_r.dcq_init;
endmodule
`default_nettype wire

// [tb/adfc_host.sv]
// Serial port host model that clocks register frames into the feature control bank.
`timescale 1ns/10ps
`default_nettype none
module adfc_host (
    input wire logic clk,
    output logic sclk,
    output logic csn,
    output logic sdio_line,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic pd_en
);
    logic hdrv;
    logic hbit;
    // A released line sinks to the pull-down, else shows the inverse of the last bit so stale data never passes.
    assign sdio_line = sdo_oe ? sdo : (hdrv ? hbit : (pd_en ? 1'b0 : ~hbit));
    initial begin
        sclk = 1'b0;
        csn = 1'b1;
        hdrv = 1'b0;
        hbit = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One frame: read flag twice, a spare bit, the address, then one data byte; sclk idles low outside frames.
    task automatic frame(input logic rd, input logic [12:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [23:0] sh;
        sh = {rd, rd, 1'b0, a, d};
        q = 8'h00;
        wait_clk(1);
        csn = 1'b0;
        for (int i = 0; i < 24; i++) begin
            hdrv = !(rd && i >= 16);
            hbit = sh[23 - i];
            wait_clk(4);
            if (rd && i >= 16) begin
                q = {q[6:0], sdio_line};
            end
            sclk = 1'b1;
            wait_clk(4);
            sclk = 1'b0;
        end
        // Chip select stays low until the write has landed.
        wait_clk(4);
        hdrv = 1'b0;
        csn = 1'b1;
        wait_clk(4);
    endtask
endmodule
`default_nettype wire

// [tb/adfc_top_assertions.sv]
// Checker of the feature control bank port behaviour, bound to the top module.
`timescale 1ns/10ps
`default_nettype none
module adfc_top_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic csn,
    input wire logic sdio_oe,
    input wire logic sdio_pulldown_en,
    input wire logic sync_pulse,
    input wire logic divider_sync,
    input wire logic output_enable_low_pin,
    input wire logic outputs_enabled,
    input wire logic low_rate_internal_oscillator_run,
    input wire logic range_pin_enable,
    input wire logic output_channel_select,
    input wire logic [2:0] correction_enable,
    input wire logic [2:0] estimation_frozen,
    input wire logic [2:0] force_initial,
    input wire logic [4:0] gain_loop_exponent,
    input wire logic [4:0] phase_loop_exponent,
    input wire logic [4:0] dc_loop_exponent,
    input wire logic [14:0] initial_gain,
    input wire logic [12:0] initial_phase,
    input wire logic [13:0] initial_dc_i,
    input wire logic [13:0] initial_dc_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Divider pulses need a cause, and a pulse never stretches past the sync pulse behind it.
    a_sync_has_cause: assert property (divider_sync |-> $past(sync_pulse)) else $error("divider sync without pulse");
    a_sync_one_cycle: assert property (divider_sync && !sync_pulse |=> !divider_sync)
        else $error("divider sync stretched");
    a_oe_pin_low: assert property (!output_enable_low_pin |-> outputs_enabled) else $error("outputs off with pin low");
    a_bw_reset_two: assert property ($rose(resetn) |-> gain_loop_exponent == 5'h02 && phase_loop_exponent == 5'h02
        && dc_loop_exponent == 5'h02) else $error("loop exponent reset wrong");
    a_qec_reset_off: assert property ($rose(resetn) |-> correction_enable == 3'h0 && estimation_frozen == 3'h0
        && force_initial == 3'h0) else $error("correction control reset wrong");
    a_pin_reset_vals: assert property ($rose(resetn) |-> sdio_pulldown_en && range_pin_enable
        && !output_channel_select) else $error("pin control reset wrong");
    // Initial words change only through a frame, never while chip select idles.
    a_init_word_stable: assert property (csn && $past(csn) |-> $stable(initial_gain) && $stable(initial_phase)
        && $stable(initial_dc_i) && $stable(initial_dc_q)) else $error("initial word changed while idle");
    a_sdo_idle_quiet: assert property (csn && $past(csn) |-> !sdio_oe) else $error("data pin driven while idle");
    c_divider_sync: cover property (divider_sync);
    c_read_drive: cover property (sdio_oe);
    c_outputs_off: cover property (!outputs_enabled);
    c_osc_run: cover property (low_rate_internal_oscillator_run);
endmodule
bind adfc_top adfc_top_checker chk_i (.clk, .resetn, .csn, .sdio_oe, .sdio_pulldown_en, .sync_pulse, .divider_sync,
    .output_enable_low_pin, .outputs_enabled, .low_rate_internal_oscillator_run, .range_pin_enable,
    .output_channel_select, .correction_enable, .estimation_frozen, .force_initial, .gain_loop_exponent,
    .phase_loop_exponent, .dc_loop_exponent, .initial_gain, .initial_phase, .initial_dc_i, .initial_dc_q);
`default_nettype wire

// [tb/tb_adc_digital_feature_control.sv]
// Self-checking testbench of the feature control register bank.
`timescale 1ns/10ps
`default_nettype none
module tb_adc_digital_feature_control;
    import adfc_pkg::*;
    logic clk, resetn, sync_pulse, encode_tick, output_enable_low_pin, sclk, csn, sdio_in, sdio_out, sdio_oe;
    logic sdio_pulldown_en, divider_sync, low_rate_internal_oscillator_run, outputs_enabled;
    logic range_pin_enable, output_channel_select;
    logic [2:0] correction_enable, estimation_frozen, force_initial;
    logic [4:0] gain_loop_exponent, phase_loop_exponent, dc_loop_exponent;
    logic [14:0] initial_gain;
    logic [12:0] initial_phase;
    logic [13:0] initial_dc_i, initial_dc_q;
    logic [7:0] em [17];
    int miscompares, comparisons, tick_per, tcnt;
    localparam logic [12:0] ADR [17] = '{13'h02a, 13'h02e, 13'h100, 13'h101, 13'h110, 13'h111, 13'h112, 13'h113,
        13'h114, 13'h116, 13'h117, 13'h118, 13'h119, 13'h11a, 13'h11b, 13'h11c, 13'h11d};
    localparam logic [7:0] RST [17] = '{8'h01, 8'h00, 8'h01, 8'h88, 8'h00, 8'h00, 8'h02, 8'h02, 8'h02, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] MSK [17] = '{8'h01, 8'h01, 8'h07, 8'h8d, 8'h3f, 8'h07, 8'h1f, 8'h1f, 8'h1f, 8'hff,
        8'h7f, 8'hff, 8'h1f, 8'hff, 8'h3f, 8'hff, 8'h3f};
    adfc_top uut (.clk, .resetn, .sclk, .csn, .sdio_in, .sdio_out, .sdio_oe, .sdio_pulldown_en, .sync_pulse,
        .divider_sync, .encode_tick, .low_rate_internal_oscillator_run, .output_enable_low_pin, .outputs_enabled,
        .range_pin_enable, .output_channel_select, .correction_enable, .estimation_frozen, .force_initial,
        .gain_loop_exponent, .phase_loop_exponent, .dc_loop_exponent, .initial_gain, .initial_phase,
        .initial_dc_i, .initial_dc_q);
    adfc_host host (.clk(clk), .sclk(sclk), .csn(csn), .sdio_line(sdio_in), .sdo(sdio_out), .sdo_oe(sdio_oe),
        .pd_en(sdio_pulldown_en));
    initial clk = 1'b0;
    always #5 clk = ~clk;
    // Encode ticks every tick_per cycles; zero keeps the encode clock stopped.
    always @(posedge clk) begin
        #1;
        tcnt = (tcnt + 1 >= tick_per) ? 0 : tcnt + 1;
        encode_tick = (tick_per != 0) && (tcnt == 0);
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.frame(1'b0, a, d, q);
    endtask
    task automatic rdchk(input logic [12:0] a, input logic [7:0] e);
        logic [7:0] q;
        host.frame(1'b1, a, 8'h00, q);
        chk(q, e);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One sync pulse, then the divider pulses seen in a short window are counted.
    task automatic sync_try(input logic [15:0] n_exp);
        logic [15:0] n;
        n = 16'h0000;
        wait_cyc(1);
        sync_pulse = 1'b1;
        wait_cyc(1);
        sync_pulse = 1'b0;
        for (int i = 0; i < 6; i++) begin
            if (divider_sync === 1'b1) begin
                n++;
            end
            wait_cyc(1);
        end
        chk(n, n_exp);
    endtask
    task automatic reset_check();
        resetn = 1'b0;
        wait_cyc(16);
        resetn = 1'b1;
        for (int i = 0; i < 17; i++) begin
            rdchk(ADR[i], RST[i]);
        end
        $display("test reset values done");
    endtask
    task automatic results();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        {resetn, sync_pulse, encode_tick, miscompares, comparisons, tick_per, tcnt} = '0;
        output_enable_low_pin = 1'b1;
        reset_check();
        // Pattern per register from its low address nibble and that nibble inverted, written unmasked into open bits too, so dropped or stuck bits show.
        for (int i = 0; i < 17; i++) begin
            em[i] = {ADR[i][3:0], ~ADR[i][3:0]} & MSK[i];
            wr(ADR[i], {ADR[i][3:0], ~ADR[i][3:0]});
        end
        for (int i = 0; i < 17; i++) begin
            rdchk(ADR[i], em[i]);
        end
        rdchk(13'h150, 8'h00);
        chk({range_pin_enable, output_channel_select}, {em[0][0], em[1][0]});
        chk(correction_enable, em[4][2:0]);
        chk(estimation_frozen, em[4][5:3]);
        chk(force_initial, em[5][2:0]);
        chk(gain_loop_exponent, em[6][4:0]);
        chk(phase_loop_exponent, em[7][4:0]);
        chk(dc_loop_exponent, em[8][4:0]);
        chk(initial_gain, {em[10][6:0], em[9]});
        chk(initial_phase, {em[12][4:0], em[11]});
        chk(initial_dc_i, {em[14][5:0], em[13]});
        chk(initial_dc_q, {em[16][5:0], em[15]});
        $display("test register map done");
        wr(13'h100, 8'h07);
        sync_try(1);
        rdchk(13'h100, 8'h05);
        sync_try(0);
        wr(13'h100, 8'h03);
        sync_try(1);
        sync_try(1);
        rdchk(13'h100, 8'h03);
        wr(13'h100, 8'h02);
        sync_try(0);
        wr(13'h100, 8'h01);
        sync_try(0);
        $display("test sync done");
        wr(13'h101, 8'h81);
        chk(outputs_enabled, 1'b0);
        chk(sdio_pulldown_en, 1'b0);
        rdchk(13'h101, 8'h81);
        output_enable_low_pin = 1'b0;
        wait_cyc(1);
        chk(outputs_enabled, 1'b1);
        wr(13'h101, 8'h00);
        output_enable_low_pin = 1'b1;
        wait_cyc(1);
        chk(outputs_enabled, 1'b1);
        chk(sdio_pulldown_en, 1'b1);
        $display("test pins done");
        wr(13'h101, 8'h08);
        tick_per = 10;
        wait_cyc(300);
        chk(low_rate_internal_oscillator_run, 1'b0);
        tick_per = 50;
        wait_cyc(300);
        chk(low_rate_internal_oscillator_run, 1'b1);
        wr(13'h101, 8'h00);
        wait_cyc(300);
        chk(low_rate_internal_oscillator_run, 1'b0);
        tick_per = 10;
        wr(13'h101, 8'h04);
        wait_cyc(300);
        chk(low_rate_internal_oscillator_run, 1'b1);
        $display("test oscillator done");
        reset_check();
        results();
    end
endmodule
`default_nettype wire
